// ===== rtl/dbsp_pkg.sv
// package of constants for the two-word-burst double-data-rate memory port
// assumes one system clock that oversamples every memory-side clock pin
package dbsp_pkg;

  // ==========================================================
  // data and address layout
  localparam int DATA_W   = 36;              // word width, four lanes
  localparam int LANE_W   = 9;               // bits per byte lane
  localparam int LANES    = 4;               // lanes per word
  localparam int ADDR_W   = 10;              // modelled array address width
  localparam int DEPTH    = 1 << ADDR_W;     // words in the modelled array
  localparam int SYNC_LEN = 2;               // flip-flops in each pin synchroniser

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000; // output word after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;         // held addresses after reset
  localparam logic [LANES-1:0]  MASK_RST = 4'hF;            // lane enables all set

  // ==========================================================
  // output sequencer states
  typedef enum logic [1:0] {
    DBSP_OUT_IDLE,                            // outputs high impedance
    DBSP_OUT_WORD2,                           // first word out, second awaited
    DBSP_OUT_TAIL                             // second word out, release awaited
  } dbsp_out_t;

endpackage

// ===== rtl/dbsp_mem.sv
// storage array of the burst memory port, one write and one read port
// assumes the caller applies clock enable; read data lag the address by one clock
`timescale 1ns/1ps
`default_nettype none

module dbsp_mem (
  input  wire logic                                  clock,
  input  wire logic                                  clockEnable,
  input  wire logic                                  wrEn,
  input  wire logic [dbsp_pkg::ADDR_W-1:0]           wrAddr,
  input  wire logic [dbsp_pkg::LANES-1:0]            wrLaneEn,
  input  wire logic [dbsp_pkg::DATA_W-1:0]           wrData,
  input  wire logic [dbsp_pkg::ADDR_W-1:0]           rdAddr,
  output logic      [dbsp_pkg::DATA_W-1:0]           rdData
);

  // ==========================================================
  // array and read register
  logic [dbsp_pkg::DATA_W-1:0] store [dbsp_pkg::DEPTH];  // word array
  logic [dbsp_pkg::DATA_W-1:0] rdData_r;                 // registered read word

  // lane-wise write, lanes with enable low keep their contents
  always_ff @(posedge clock) begin
    if (clockEnable && wrEn) begin
      for (int i = 0; i < dbsp_pkg::LANES; i++) begin
        if (wrLaneEn[i]) begin
          store[wrAddr][i*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] <=
            wrData[i*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W];
        end
      end
    end
  end

  // read word registered every enabled clock
  always_ff @(posedge clock) begin
    if (clockEnable) begin
      rdData_r <= store[rdAddr];
    end
  end

  assign rdData = rdData_r;

endmodule // dbsp_mem

`default_nettype wire

// ===== rtl/dbsp_port.sv
// command and data port of a two-word-burst double-data-rate static memory
// assumes all memory-side pins are asynchronous and far slower than clock
//
// Summary of operation
// - write: load low, select low; data next
// - read: word one negative, two positive output
// - offsets count positive input clock cycles
// - load high: no operation, outputs released once any pending burst ends
// - stopped clocks: outputs hold their state
// - second burst address inverts address bit zero
// - write data taken on both input edges
// - output clocks time reads, or input pair
// - narrow variant: two lane selects per word; only the four-select word is built here
// - all selects low writes whole word
// - each select guards its nine-bit lane
// - last write word posted until next write
// - both output clocks high at start: single
// - after last word, release outputs on positive
`timescale 1ns/1ps
`default_nettype none

module dbsp_port (
  input  wire logic                                  clock,
  input  wire logic                                  reset,
  input  wire logic                                  clockEnable,
  input  wire logic                                  inClkPin,
  input  wire logic                                  inClkNPin,
  input  wire logic                                  outClkPin,
  input  wire logic                                  outClkNPin,
  input  wire logic                                  load_select_n,
  input  wire logic                                  readWrite,
  input  wire logic [dbsp_pkg::ADDR_W-1:0]           addrPin,
  input  wire logic [dbsp_pkg::DATA_W-1:0]           dataInPin,
  input  wire logic [dbsp_pkg::LANES-1:0]            byte_write_select_n,
  output logic      [dbsp_pkg::DATA_W-1:0]           dataOut,
  output logic                                       dataOutEn
);

  // ==========================================================
  // helper functions
  // partner word address of a burst
  function automatic logic [dbsp_pkg::ADDR_W-1:0] burstPair(
    input logic [dbsp_pkg::ADDR_W-1:0] a
  );
    burstPair = {a[dbsp_pkg::ADDR_W-1:1], ~a[0]};
  endfunction

  // lane enables from active-low selects
  function automatic logic [dbsp_pkg::LANES-1:0] laneEnable(
    input logic [dbsp_pkg::LANES-1:0] selN
  );
    laneEnable = ~selN;
  endfunction

  // bit mask widened from lane enables
  function automatic logic [dbsp_pkg::DATA_W-1:0] laneBits(
    input logic [dbsp_pkg::LANES-1:0] en
  );
    laneBits = '0;
    for (int i = 0; i < dbsp_pkg::LANES; i++) begin
      laneBits[i*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] = {dbsp_pkg::LANE_W{en[i]}};
    end
  endfunction

  // ==========================================================
  // pin synchronisers, two flops then an edge history flop
  localparam int SW = 4 + 2 + dbsp_pkg::ADDR_W + dbsp_pkg::DATA_W + dbsp_pkg::LANES;

  logic [SW-1:0] syncA_r;            // first stage, read only by second
  logic [SW-1:0] syncB_r;            // second stage, safe to use
  logic [3:0]    clkPrev_r;          // clock pins one clock earlier
  logic [SW-1:0] syncA_nxt;
  logic [SW-1:0] syncB_nxt;
  logic [3:0]    clkPrev_nxt;

  // next values of the synchroniser chain
  always_comb begin
    syncA_nxt   = {inClkPin, inClkNPin, outClkPin, outClkNPin, load_select_n, readWrite,
                   addrPin, dataInPin, byte_write_select_n};
    syncB_nxt   = syncA_r;
    clkPrev_nxt = syncB_r[SW-1 -: 4];
  end

  // chain registers, frozen while clock enable is low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      syncA_r   <= '0;
      syncB_r   <= '0;
      clkPrev_r <= 4'h0;
    end else if (clockEnable) begin
      syncA_r   <= syncA_nxt;
      syncB_r   <= syncB_nxt;
      clkPrev_r <= clkPrev_nxt;
    end
  end

  // unpacked synchronised pins
  logic [3:0]                  clkNow;    // K, K#, C, C# levels
  logic                        loadN;     // load select, active low
  logic                        rdSel;     // read when high
  logic [dbsp_pkg::ADDR_W-1:0] addrS;     // sampled address
  logic [dbsp_pkg::DATA_W-1:0] dataS;     // sampled write data
  logic [dbsp_pkg::LANES-1:0]  selNS;     // sampled lane selects
  assign {clkNow, loadN, rdSel, addrS, dataS, selNS} = syncB_r;

  // ==========================================================
  // single clock strap, caught once after reset release
  logic singleClk_r;                 // output timing from input pair
  logic strapDone_r;                 // strap already caught
  logic singleClk_nxt;
  logic strapDone_nxt;
  logic syncReady_r;                 // chain filled after reset
  logic [1:0] fillCnt_r;             // chain fill counter
  logic [1:0] fillCnt_nxt;
  logic syncReady_nxt;

  // strap waits until synchronised levels are valid
  always_comb begin
    singleClk_nxt = singleClk_r;
    strapDone_nxt = strapDone_r;
    if (!strapDone_r && syncReady_r) begin
      singleClk_nxt = clkNow[1] & clkNow[0];
      strapDone_nxt = 1'b1;
    end
  end

  // counts the synchroniser fill after reset
  always_comb begin
    fillCnt_nxt   = fillCnt_r;
    syncReady_nxt = syncReady_r;
    if (!syncReady_r) begin
      fillCnt_nxt = fillCnt_r + 2'h1;
      if (fillCnt_r == 2'(dbsp_pkg::SYNC_LEN)) begin
        syncReady_nxt = 1'b1;
      end
    end
  end

  // strap registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      singleClk_r <= 1'b0;
      strapDone_r <= 1'b0;
      fillCnt_r   <= 2'h0;
      syncReady_r <= 1'b0;
    end else if (clockEnable) begin
      singleClk_r <= singleClk_nxt;
      strapDone_r <= strapDone_nxt;
      fillCnt_r   <= fillCnt_nxt;
      syncReady_r <= syncReady_nxt;
    end
  end

  // ==========================================================
  // clock edge events; none occur while the pins stand still
  logic kRise;                       // positive input clock rise
  logic knRise;                      // negative input clock rise
  logic oRise;                       // positive output timing rise
  logic onRise;                      // negative output timing rise
  assign kRise  = syncReady_r & strapDone_r & clkNow[3] & ~clkPrev_r[3];
  assign knRise = syncReady_r & strapDone_r & clkNow[2] & ~clkPrev_r[2];
  assign oRise  = singleClk_r ? kRise  : (syncReady_r & strapDone_r & clkNow[1] & ~clkPrev_r[1]);
  assign onRise = singleClk_r ? knRise : (syncReady_r & strapDone_r & clkNow[0] & ~clkPrev_r[0]);

  // ==========================================================
  // command and write path
  logic                        wrPend_r;   // write taken, first word due
  logic [dbsp_pkg::ADDR_W-1:0] wrAddr_r;   // address of that write
  logic                        wr2Pend_r;  // second word due on K#
  logic [dbsp_pkg::ADDR_W-1:0] wr2Addr_r;  // second word address
  logic                        postVal_r;  // posted word held
  logic [dbsp_pkg::ADDR_W-1:0] postAddr_r; // posted word address
  logic [dbsp_pkg::DATA_W-1:0] postData_r; // posted word data
  logic [dbsp_pkg::LANES-1:0]  postEn_r;   // posted word lane enables
  logic                        rdPend_r;   // read taken, arm on next K
  logic [dbsp_pkg::ADDR_W-1:0] rdAddr_r;   // address of that read
  logic                        wrPend_nxt;
  logic [dbsp_pkg::ADDR_W-1:0] wrAddr_nxt;
  logic                        wr2Pend_nxt;
  logic [dbsp_pkg::ADDR_W-1:0] wr2Addr_nxt;
  logic                        postVal_nxt;
  logic [dbsp_pkg::ADDR_W-1:0] postAddr_nxt;
  logic [dbsp_pkg::DATA_W-1:0] postData_nxt;
  logic [dbsp_pkg::LANES-1:0]  postEn_nxt;
  logic                        rdPend_nxt;
  logic [dbsp_pkg::ADDR_W-1:0] rdAddr_nxt;
  logic                        armSet;     // read armed this clock
  logic                        memWr;      // array write strobe
  logic [dbsp_pkg::ADDR_W-1:0] memWrAddr;  // array write address
  logic [dbsp_pkg::DATA_W-1:0] memWrData;  // array write data
  logic [dbsp_pkg::LANES-1:0]  memWrEn;    // array lane enables

  // command decode at K rise, data capture at K and K# rises
  always_comb begin
    wrPend_nxt   = wrPend_r;
    wrAddr_nxt   = wrAddr_r;
    wr2Pend_nxt  = wr2Pend_r;
    wr2Addr_nxt  = wr2Addr_r;
    postVal_nxt  = postVal_r;
    postAddr_nxt = postAddr_r;
    postData_nxt = postData_r;
    postEn_nxt   = postEn_r;
    rdPend_nxt   = rdPend_r;
    rdAddr_nxt   = rdAddr_r;
    armSet       = 1'b0;
    memWr        = 1'b0;
    memWrAddr    = wrAddr_r;
    memWrData    = dataS;
    memWrEn      = laneEnable(selNS);
    if (kRise) begin
      // first word of the earlier write, cycle t + 1
      if (wrPend_r) begin
        memWr       = 1'b1;
        wr2Pend_nxt = 1'b1;
        wr2Addr_nxt = burstPair(wrAddr_r);
      end
      // earlier read now armed for the output side
      armSet = rdPend_r;
      // new command; load high starts nothing
      wrPend_nxt = ~loadN & ~rdSel;
      rdPend_nxt = ~loadN & rdSel;
      if (!loadN) begin
        wrAddr_nxt = addrS;
        rdAddr_nxt = addrS;
      end
    end
    if (knRise && wr2Pend_r) begin
      // second word posted, older posted word committed now
      wr2Pend_nxt  = 1'b0;
      memWr        = postVal_r;
      memWrAddr    = postAddr_r;
      memWrData    = postData_r;
      memWrEn      = postEn_r;
      postVal_nxt  = 1'b1;
      postAddr_nxt = wr2Addr_r;
      postData_nxt = dataS;
      postEn_nxt   = laneEnable(selNS);
    end
  end

  // write path registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wrPend_r   <= 1'b0;
      wrAddr_r   <= dbsp_pkg::ADDR_RST;
      wr2Pend_r  <= 1'b0;
      wr2Addr_r  <= dbsp_pkg::ADDR_RST;
      postVal_r  <= 1'b0;
      postAddr_r <= dbsp_pkg::ADDR_RST;
      postData_r <= dbsp_pkg::DATA_RST;
      postEn_r   <= dbsp_pkg::MASK_RST;
      rdPend_r   <= 1'b0;
      rdAddr_r   <= dbsp_pkg::ADDR_RST;
    end else if (clockEnable) begin
      wrPend_r   <= wrPend_nxt;
      wrAddr_r   <= wrAddr_nxt;
      wr2Pend_r  <= wr2Pend_nxt;
      wr2Addr_r  <= wr2Addr_nxt;
      postVal_r  <= postVal_nxt;
      postAddr_r <= postAddr_nxt;
      postData_r <= postData_nxt;
      postEn_r   <= postEn_nxt;
      rdPend_r   <= rdPend_nxt;
      rdAddr_r   <= rdAddr_nxt;
    end
  end

  // ==========================================================
  // output sequencer
  dbsp_pkg::dbsp_out_t         outSt_r;    // output phase
  logic                        arm_r;      // first word due on next negative rise
  logic [dbsp_pkg::ADDR_W-1:0] armAddr_r;  // address of armed read
  logic [dbsp_pkg::ADDR_W-1:0] w2Addr_r;   // address of second word
  logic [dbsp_pkg::DATA_W-1:0] dataOut_r;  // driven word
  logic                        dataOutEn_r;// output drive enable
  dbsp_pkg::dbsp_out_t         outSt_nxt;
  logic                        arm_nxt;
  logic [dbsp_pkg::ADDR_W-1:0] armAddr_nxt;
  logic [dbsp_pkg::ADDR_W-1:0] w2Addr_nxt;
  logic [dbsp_pkg::DATA_W-1:0] dataOut_nxt;
  logic                        dataOutEn_nxt;
  logic [dbsp_pkg::ADDR_W-1:0] memRdAddr;  // array read address
  logic [dbsp_pkg::DATA_W-1:0] memRdData;  // array read word
  logic [dbsp_pkg::DATA_W-1:0] rdWord;     // read word with posted bypass

  // second word address has priority while it is still owed
  assign memRdAddr = (outSt_r == dbsp_pkg::DBSP_OUT_WORD2) ? w2Addr_r : armAddr_r;

  // newest data: posted lanes override the array copy
  always_comb begin
    rdWord = memRdData;
    if (postVal_r && (postAddr_r == memRdAddr)) begin
      rdWord = (memRdData & ~laneBits(postEn_r)) | (postData_r & laneBits(postEn_r));
    end
  end

  // word one on negative rise, word two on positive, release after
  always_comb begin
    outSt_nxt     = outSt_r;
    arm_nxt       = arm_r;
    armAddr_nxt   = armAddr_r;
    w2Addr_nxt    = w2Addr_r;
    dataOut_nxt   = dataOut_r;
    dataOutEn_nxt = dataOutEn_r;
    case (outSt_r)
      dbsp_pkg::DBSP_OUT_WORD2: begin
        if (oRise) begin
          dataOut_nxt = rdWord;
          outSt_nxt   = dbsp_pkg::DBSP_OUT_TAIL;
        end
      end
      dbsp_pkg::DBSP_OUT_TAIL: begin
        if (oRise) begin
          dataOutEn_nxt = 1'b0;
          outSt_nxt     = dbsp_pkg::DBSP_OUT_IDLE;
        end
      end
      default: begin
        outSt_nxt = dbsp_pkg::DBSP_OUT_IDLE;
      end
    endcase
    // armed read starts its burst, even during a pending tail
    if (onRise && arm_r && (outSt_r != dbsp_pkg::DBSP_OUT_WORD2)) begin
      dataOut_nxt   = rdWord;
      dataOutEn_nxt = 1'b1;
      arm_nxt       = 1'b0;
      w2Addr_nxt    = burstPair(armAddr_r);
      outSt_nxt     = dbsp_pkg::DBSP_OUT_WORD2;
    end
    // a new arm wins over the clear in the same clock
    if (armSet) begin
      arm_nxt     = 1'b1;
      armAddr_nxt = rdAddr_r;
    end
  end

  // sequencer registers; powers up released
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      outSt_r     <= dbsp_pkg::DBSP_OUT_IDLE;
      arm_r       <= 1'b0;
      armAddr_r   <= dbsp_pkg::ADDR_RST;
      w2Addr_r    <= dbsp_pkg::ADDR_RST;
      dataOut_r   <= dbsp_pkg::DATA_RST;
      dataOutEn_r <= 1'b0;
    end else if (clockEnable) begin
      outSt_r     <= outSt_nxt;
      arm_r       <= arm_nxt;
      armAddr_r   <= armAddr_nxt;
      w2Addr_r    <= w2Addr_nxt;
      dataOut_r   <= dataOut_nxt;
      dataOutEn_r <= dataOutEn_nxt;
    end
  end

  assign dataOut   = dataOut_r;
  assign dataOutEn = dataOutEn_r;

  // ==========================================================
  // storage array
  dbsp_mem u_mem (
    .clock       (clock),
    .clockEnable (clockEnable),
    .wrEn        (memWr),
    .wrAddr      (memWrAddr),
    .wrLaneEn    (memWrEn),
    .wrData      (memWrData),
    .rdAddr      (memRdAddr),
    .rdData      (memRdData)
  );

endmodule // dbsp_port

`default_nettype wire

// ===== testbench/dbsp_port_monitor.sv
// checker of the burst memory port, watching its pins only
// assumes output clocks rise together with the input clock pair
`timescale 1ns/1ps
`default_nettype none
module dbsp_port_monitor (
  input wire logic                        clock,
  input wire logic                        reset,
  input wire logic                        clockEnable,
  input wire logic                        inClkPin,
  input wire logic                        inClkNPin,
  input wire logic                        outClkPin,
  input wire logic                        outClkNPin,
  input wire logic                        load_select_n,
  input wire logic                        readWrite,
  input wire logic [dbsp_pkg::ADDR_W-1:0] addrPin,
  input wire logic [dbsp_pkg::DATA_W-1:0] dataInPin,
  input wire logic [dbsp_pkg::LANES-1:0]  byte_write_select_n,
  input wire logic [dbsp_pkg::DATA_W-1:0] dataOut,
  input wire logic                        dataOutEn
);
  // ==========================================================
  // helper: input clock rises since the last read command
  logic       kPrev_r;   // input clock one clock ago
  logic       kPrev_nxt; // next level
  logic [1:0] kCnt_r;    // rises since read, stops at 3
  logic [1:0] kCnt_nxt;  // next count
  logic       kRise;     // input clock rose
  logic [1:0] rdHist_r;  // read taken at the last two rises
  logic [1:0] rdHist_nxt;// next history
  logic       nRef;      // negative output timing clock
  logic       pRef;      // positive output timing clock
  // both output clocks high only while parked for the single clock strap
  assign nRef = (outClkPin & outClkNPin) ? inClkNPin : outClkNPin;
  assign pRef = (outClkPin & outClkNPin) ? inClkPin : outClkPin;
  // next count
  always_comb begin
    kPrev_nxt = inClkPin;
    kRise     = inClkPin & ~kPrev_r;
    kCnt_nxt  = kCnt_r;
    rdHist_nxt = kRise ? {rdHist_r[0], ~load_select_n & readWrite} : rdHist_r;
    if (kRise && !load_select_n && readWrite) begin
      kCnt_nxt = 2'h0; // read taken
    end else if (kRise && kCnt_r != 2'h3) begin
      kCnt_nxt = kCnt_r + 2'h1; // one more rise
    end
  end
  // registers only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      kPrev_r <= 1'h0;
      kCnt_r  <= 2'h3;
      rdHist_r <= 2'h0;
    end else begin
      kPrev_r <= kPrev_nxt;
      kCnt_r  <= kCnt_nxt;
      rdHist_r <= rdHist_nxt;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // negative output clock rose a few clocks back
  sequence s_nRise; $past(nRef) && !$past(nRef, 5); endsequence
  // positive output clock rose a few clocks back
  sequence s_pRise; $past(pRef) && !$past(pRef, 5); endsequence
  // no pin clock moved
  sequence s_still;
    $stable(inClkPin) && $stable(inClkNPin) && $stable(outClkPin) && $stable(outClkNPin);
  endsequence
  property p_rstQuiet; $fell(reset) |-> !dataOutEn && dataOut == dbsp_pkg::DATA_RST; endproperty
  property p_enRise; $rose(dataOutEn) |-> s_nRise; endproperty
  property p_enFall; $fell(dataOutEn) |-> s_pRise; endproperty
  property p_hold; s_still [*6] |-> $stable(dataOut) && $stable(dataOutEn); endproperty
  property p_burst; $rose(dataOutEn) |-> dataOutEn [*8]; endproperty
  property p_latency; $rose(dataOutEn) |-> rdHist_r[1]; endproperty
  property p_release; (kCnt_r == 2'h3) [*6] |-> !dataOutEn; endproperty
  property p_nopIdle; kRise && load_select_n && kCnt_r == 2'h3 |-> !dataOutEn [*8]; endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("outputs not idle after reset");
  a_enRise: assert property (p_enRise) else $error("drive began off negative edge");
  a_enFall: assert property (p_enFall) else $error("release not after positive edge");
  a_hold: assert property (p_hold) else $error("outputs moved with clocks stopped");
  a_burst: assert property (p_burst) else $error("read burst cut short");
  a_latency: assert property (p_latency) else $error("first word at wrong cycle");
  a_release: assert property (p_release) else $error("outputs driven after burst");
  a_nopIdle: assert property (p_nopIdle) else $error("deselect drove outputs");
endmodule // dbsp_port_monitor
bind dbsp_port dbsp_port_monitor i_dbsp_port_monitor (
  .clock(clock), .reset(reset), .clockEnable(clockEnable), .inClkPin(inClkPin),
  .inClkNPin(inClkNPin), .outClkPin(outClkPin), .outClkNPin(outClkNPin),
  .load_select_n(load_select_n), .readWrite(readWrite), .addrPin(addrPin),
  .dataInPin(dataInPin), .byte_write_select_n(byte_write_select_n),
  .dataOut(dataOut), .dataOutEn(dataOutEn)
);
`default_nettype wire

// ===== testbench/dbsp_ctl.sv
// controller model driving pin clocks, commands and write data
// assumes one call per input clock period, quarters of six clocks
`timescale 1ns/1ps
`default_nettype none
module dbsp_ctl (
  input  wire logic        clock,
  input  wire logic [35:0] dataOut,
  input  wire logic        dataOutEn,
  output logic             kPin,
  output logic             kNPin,
  output logic             cPin,
  output logic             cNPin,
  output logic             loadN,
  output logic             rw,
  output logic [9:0]       addr,
  output logic [35:0]      din,
  output logic [3:0]       selN
);
  logic [35:0] qHi;  // word seen before negative edge
  logic [35:0] qLo;  // word seen before next positive edge
  logic        enHi; // enable seen with qHi
  logic        enLo; // enable seen with qLo
  logic        cHold = 1'h0; // output clocks parked high
  // start levels, dual clock strap
  initial begin
    kPin = 1'h0;
    kNPin = 1'h1;
    cPin = 1'h0;
    cNPin = 1'h1;
    loadN = 1'h1;
    rw = 1'h0;
    addr = 10'h000;
    din = 36'h0;
    selN = 4'hF;
  end
  // wait clocks, clocks held meanwhile
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one input clock period; data words only when dv
  task automatic kcyc(input logic l, input logic r, input logic [9:0] a, input logic dv,
                      input logic [35:0] d0 = 36'h0, input logic [3:0] s0 = 4'hF,
                      input logic [35:0] d1 = 36'h0, input logic [3:0] s1 = 4'hF);
    loadN = l;
    rw = r;
    addr = a;
    din = dv ? d0 : ~din;
    selN = dv ? s0 : 4'h0;
    step(6);
    kPin = 1'h1;
    kNPin = 1'h0;
    cPin = 1'h1;
    cNPin = cHold;
    step(6);
    qHi = dataOut;
    enHi = dataOutEn;
    loadN = ~l;
    rw = ~r;
    addr = ~a;
    din = dv ? d1 : ~din;
    selN = dv ? s1 : 4'h0;
    step(6);
    kPin = 1'h0;
    kNPin = 1'h1;
    cPin = cHold;
    cNPin = 1'h1;
    step(6);
    qLo = dataOut;
    enLo = dataOutEn;
  endtask
endmodule // dbsp_ctl
`default_nettype wire

// ===== testbench/test_dbsp_port.sv
// self-checking bench of the burst memory port
// assumes the controller model in dbsp_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module test_dbsp_port;
  logic        clock = 1'h0; // system clock
  logic        reset;        // asynchronous reset
  logic        clockEnable;  // held on
  logic        kPin, kNPin, cPin, cNPin, loadN, rw;
  logic [9:0]  addr;         // address pins
  logic [35:0] din;          // write data pins
  logic [3:0]  selN;         // lane selects
  logic [35:0] dataOut;      // read data
  logic        dataOutEn;    // read drive
  logic [35:0] sh [0:1023];  // expected array
  int          err_count;    // mismatches
  int          num_checks;   // comparisons
  dbsp_port i_dbsp_port (.clock(clock), .reset(reset), .clockEnable(clockEnable),
    .inClkPin(kPin), .inClkNPin(kNPin), .outClkPin(cPin), .outClkNPin(cNPin),
    .load_select_n(loadN), .readWrite(rw), .addrPin(addr), .dataInPin(din),
    .byte_write_select_n(selN), .dataOut(dataOut), .dataOutEn(dataOutEn));
  dbsp_ctl i_dbsp_ctl (.clock(clock), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .kPin(kPin), .kNPin(kNPin), .cPin(cPin), .cNPin(cNPin), .loadN(loadN), .rw(rw),
    .addr(addr), .din(din), .selN(selN));
  always #20 clock = ~clock;
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // lanes with select low take the new word
  function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n,
                                      input logic [3:0] s);
    mrg = o;
    for (int i = 0; i < 4; i++) if (!s[i]) mrg[i*9 +: 9] = n[i*9 +: 9];
  endfunction
  task automatic nop();
    i_dbsp_ctl.kcyc(1'h1, 1'h1, 10'h3FF, 1'h0);
  endtask
  task automatic wr(input logic [9:0] a, input logic [35:0] d0, input logic [3:0] s0,
                    input logic [35:0] d1, input logic [3:0] s1);
    i_dbsp_ctl.kcyc(1'h0, 1'h0, a, 1'h0);
    i_dbsp_ctl.kcyc(1'h1, 1'h1, ~a, 1'h1, d0, s0, d1, s1);
    sh[a] = mrg(sh[a], d0, s0);
    sh[a ^ 10'h001] = mrg(sh[a ^ 10'h001], d1, s1);
  endtask
  task automatic rdChk(input logic [9:0] a);
    nop();
    chk(i_dbsp_ctl.enHi, 1'h0);
    chk(i_dbsp_ctl.enLo, 1'h1);
    chk(i_dbsp_ctl.qLo, sh[a]);
    nop();
    chk(i_dbsp_ctl.enHi, 1'h1);
    chk(i_dbsp_ctl.qHi, sh[a ^ 10'h001]);
    nop();
    chk(i_dbsp_ctl.enHi, 1'h0);
  endtask
  task automatic rd(input logic [9:0] a);
    i_dbsp_ctl.kcyc(1'h0, 1'h1, a, 1'h0);
    rdChk(a);
  endtask
  task automatic t_wrRd();
    nop();
    chk({i_dbsp_ctl.enHi, i_dbsp_ctl.enLo}, 2'h0);
    wr(10'h010, 36'h1_2345_6789, 4'h0, 36'hF_EDCB_A987, 4'h0);
    rd(10'h010);
    wr(10'h021, 36'h5_5AA5_0FF0, 4'h0, 36'hA_A55A_F00F, 4'h0);
    rd(10'h020);
  endtask
  task automatic t_b2b();
    i_dbsp_ctl.kcyc(1'h0, 1'h1, 10'h010, 1'h0);
    i_dbsp_ctl.kcyc(1'h0, 1'h1, 10'h021, 1'h0);
    chk(i_dbsp_ctl.qLo, sh[10'h010]);
    nop();
    chk(i_dbsp_ctl.qHi, sh[10'h011]);
    chk(i_dbsp_ctl.qLo, sh[10'h021]);
    nop();
    chk(i_dbsp_ctl.qHi, sh[10'h020]);
    nop();
    chk(i_dbsp_ctl.enHi, 1'h0);
  endtask
  task automatic t_lanes();
    for (int i = 0; i < 5; i++) begin
      wr(10'h040, 36'h0, 4'h0, 36'hF_FFFF_FFFF, 4'h0);
      wr(10'h040, 36'hF_FFFF_FFFF, ~(4'h1 << i), 36'h0, ~(4'h8 >> i));
      rd(10'h040);
    end
  endtask
  task automatic t_stop();
    i_dbsp_ctl.kcyc(1'h0, 1'h1, 10'h041, 1'h0);
    nop();
    i_dbsp_ctl.step(40);
    chk(dataOut, sh[10'h041]);
    chk(dataOutEn, 1'h1);
    nop();
    chk(i_dbsp_ctl.qHi, sh[10'h040]);
    nop();
  endtask
  task automatic t_post();
    i_dbsp_ctl.kcyc(1'h0, 1'h0, 10'h081, 1'h0);
    i_dbsp_ctl.kcyc(1'h0, 1'h1, 10'h080, 1'h1, 36'h3_0303_0303, 4'h0, 36'hC_C0C0_C0C0, 4'h0);
    sh[10'h081] = 36'h3_0303_0303;
    sh[10'h080] = 36'hC_C0C0_C0C0;
    rdChk(10'h080);
    wr(10'h100, 36'h0_1111_2222, 4'h0, 36'h0_3333_4444, 4'h0);
    rd(10'h080);
  endtask
  // second reset with output clocks parked high: single clock strap
  task automatic t_single();
    reset = 1'h1;
    i_dbsp_ctl.cPin = 1'h1;
    i_dbsp_ctl.cHold = 1'h1;
    i_dbsp_ctl.step(4);
    reset = 1'h0;
    rd(10'h010);
  endtask
  task automatic conclude();
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    reset = 1'h1;
    clockEnable = 1'h1;
    err_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clock);
    #1 reset = 1'h0;
    t_wrRd();
    t_b2b();
    t_lanes();
    t_stop();
    t_post();
    t_single();
    conclude();
  end
  // watchdog, about 2.6 times the expected run
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    conclude();
  end
endmodule // test_dbsp_port
`default_nettype wire
